// ===== logic/ufet_pkg.sv
// Package with register map, field positions, reset values and shared types of the serial port.
package ufet_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] OFS_STATUS   = 5'h00;
  localparam logic [4:0] OFS_CONTROL1 = 5'h04;
  localparam logic [4:0] OFS_CONTROL2 = 5'h08;
  localparam logic [4:0] OFS_DATA     = 5'h0C;
  localparam logic [4:0] OFS_BAUD     = 5'h10;

  // Field positions in serial_control_one.
  localparam int C1_GLOBAL_EN  = 7;
  localparam int C1_WORD_LEN   = 6;
  localparam int C1_PARITY_EN  = 5;
  localparam int C1_PARITY_ODD = 4;
  localparam int C1_STOP_TWO   = 3;
  localparam int C1_ADDR_DET   = 2;
  localparam int C1_BREAK      = 1;
  localparam int C1_NINTH      = 0;

  // Field positions in serial_control_two.
  localparam int C2_TX_EN  = 7;
  localparam int C2_RX_EN  = 6;
  localparam int C2_SPEED  = 5;
  localparam int C2_TE_IE  = 0;

  // Field positions in serial_status_register.
  localparam int ST_LINE     = 8;
  localparam int ST_PAR_ERR  = 7;
  localparam int ST_NOISE    = 6;
  localparam int ST_FRAME    = 5;
  localparam int ST_OVERRUN  = 4;
  localparam int ST_RX_IDLE  = 3;
  localparam int ST_RX_AVAIL = 2;
  localparam int ST_TX_IDLE  = 1;
  localparam int ST_TX_EMPTY = 0;

  // Reset values: 8 data bits, no parity, one stop bit, everything off.
  localparam logic [7:0] RST_CONTROL1 = 8'h00;
  localparam logic [7:0] RST_CONTROL2 = 8'h00;
  localparam logic [7:0] RST_BAUD     = 8'h00;

  // Baud prescale in low and high speed modes, and break length in bits.
  localparam logic [5:0] PRE_LOW_MAX  = 6'h3F;
  localparam logic [5:0] PRE_HIGH_MAX = 6'h0F;
  localparam logic [3:0] BREAK_BITS   = 4'hD;
  localparam logic [3:0] LEN_EIGHT    = 4'h8;
  localparam logic [3:0] LEN_NINE     = 4'h9;

  // Transmit engine states.
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_STOP  = 5'b01000,
    TX_BREAK = 5'b10000
  } ufet_tx_state_e;

  // One Avalon-MM request as seen by the slave.
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } ufet_bus_req_s;

  // Frame format used by the transmit path.
  typedef struct packed {
    logic word_nine;
    logic parity_en;
    logic parity_odd;
    logic stop_two;
  } ufet_format_s;

endpackage

// ===== logic/ufet_baud_gen.sv
// Baud generator: prescaler of 16 or 64 followed by an 8-bit divisor counter.
`timescale 1ns/1ps
module ufet_baud_gen
  import ufet_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // Clock, reset and enable.
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // Control.
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic             speed,
  input  wire logic [DIV_W-1:0] divisor,
  // One pulse per bit period.
  output logic                  tick
);

  logic [5:0]       pre;
  logic [DIV_W-1:0] div;
  logic [5:0]       pre_max;

  assign pre_max = speed ? PRE_HIGH_MAX : PRE_LOW_MAX;
  assign tick    = run && !restart && (pre == pre_max) && (div == divisor);

  // Counters count up to the prescale limit and the divisor, then return to zero; run low or restart clears them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre <= '0;
      div <= '0;
    end else if (ce) begin
      if (!run || restart) begin
        pre <= '0;
        div <= '0;
      end else if (pre == pre_max) begin
        pre <= '0;
        div <= (div == divisor) ? '0 : div + 1'b1;
      end else begin
        pre <= pre + 6'h01;
      end
    end
  end

endmodule

// ===== logic/ufet_pin_sync.sv
// Three-stage synchroniser for a pin input; a change counts when stages two and three agree.
`timescale 1ns/1ps
module ufet_pin_sync (
  // Clock, reset and enable.
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  // Pin and filtered level.
  input  wire logic pin,
  output logic      level
);

  logic [2:0] stage;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= 3'h7;
    end else if (ce) begin
      stage <= {stage[1:0], pin};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level <= 1'b1;
    end else if (ce && (stage[1] == stage[2])) begin
      level <= stage[2];
    end
  end

endmodule

// ===== logic/ufet_uart.sv
// Serial port top: Avalon-MM registers, frame format, enable control and transmit path.
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module ufet_uart
  import ufet_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // Clock, reset and enable.
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  // Avalon-MM slave.
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Serial pins.
  output logic             SERIAL_OUT_PIN,
  output logic             SERIAL_OUT_OE,
  input  wire logic        SERIAL_IN_PIN,
  output logic             SERIAL_IN_ACTIVE,
  // Shared interrupt request.
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus request and handshake.
  ufet_bus_req_s  req;
  logic           ack;
  logic           take;
  logic           wr_ctrl1;
  logic           wr_ctrl2;
  logic           wr_data;
  logic           wr_baud;
  logic           rd_status;

  assign req.read       = AVS_READ;
  assign req.write      = AVS_WRITE;
  assign req.address    = AVS_ADDRESS;
  assign req.byteenable = AVS_BYTEENABLE;
  assign req.writedata  = AVS_WRITEDATA;

  // Every request is answered one cycle after it appears.
  assign AVS_WAITREQUEST = (req.read || req.write) && !ack;
  assign take            = CE && (req.read || req.write) && !ack;

  assign wr_ctrl1  = take && req.write && req.byteenable[0] && (req.address == OFS_CONTROL1);
  assign wr_ctrl2  = take && req.write && req.byteenable[0] && (req.address == OFS_CONTROL2);
  assign wr_data   = take && req.write && req.byteenable[0] && (req.address == OFS_DATA);
  assign wr_baud   = take && req.write && req.byteenable[0] && (req.address == OFS_BAUD);
  assign rd_status = take && req.read && (req.address == OFS_STATUS);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack <= 1'b0;
    end else if (CE) begin
      ack <= (req.read || req.write) && !ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.
  logic [7:0]       control1;
  logic [7:0]       control2;
  logic [DIV_W-1:0] baud_divisor;
  logic             port_global_enable;
  logic             transmit_enable;
  logic             send_break_bit;
  logic             transmit_empty_irq_enable;
  ufet_format_s     fmt;
  logic             next_global;

  assign port_global_enable        = control1[C1_GLOBAL_EN];
  assign send_break_bit            = control1[C1_BREAK];
  assign transmit_enable           = control2[C2_TX_EN];
  assign transmit_empty_irq_enable = control2[C2_TE_IE];
  assign fmt.word_nine  = control1[C1_WORD_LEN];
  assign fmt.parity_en  = control1[C1_PARITY_EN];
  assign fmt.parity_odd = control1[C1_PARITY_ODD];
  assign fmt.stop_two   = control1[C1_STOP_TWO];
  assign next_global    = wr_ctrl1 ? req.writedata[C1_GLOBAL_EN] : port_global_enable;

  // Format bits survive a disable; only the break bit is cleared by it.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      control1 <= RST_CONTROL1;
    end else if (CE) begin
      if (wr_ctrl1) begin
        control1 <= req.writedata[7:0];
      end
      if (!next_global) begin
        control1[C1_BREAK] <= 1'b0;
      end
    end
  end

  // Transmit and receive enables cannot stand while the port is disabled.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      control2 <= RST_CONTROL2;
    end else if (CE) begin
      if (wr_ctrl2) begin
        control2 <= req.writedata[7:0];
      end
      if (!next_global) begin
        control2[C2_TX_EN] <= 1'b0;
        control2[C2_RX_EN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      baud_divisor <= RST_BAUD[DIV_W-1:0];
    end else if (CE && wr_baud) begin
      baud_divisor <= req.writedata[DIV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame builder: ninth bit from control, parity in the last data position.
  function automatic logic [8:0] build_frame(input logic [7:0] data, input logic ninth,
                                             input ufet_format_s f);
    logic [8:0] w;
    w = {ninth, data};
    if (f.parity_en && f.word_nine) begin
      w[8] = (^data) ^ f.parity_odd;
    end else if (f.parity_en) begin
      w[7] = (^data[6:0]) ^ f.parity_odd;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Holding register, shift register and transmit state.
  ufet_tx_state_e state;
  ufet_tx_state_e next_state;
  logic [7:0]     holding;
  logic           hold_full;
  logic [8:0]     transmit_shift_register;
  logic [3:0]     bit_cnt;
  logic           tick;
  logic           tx_live;
  logic           load;
  logic           break_start;
  logic           frame_done;
  logic           accept_data;
  logic [3:0]     frame_len;
  logic           armed;
  logic           transmit_empty_flag;
  logic           transmit_idle_flag;
  logic           receive_idle_flag;
  logic           rx_errs_clear;
  logic           line_level;

  assign tx_live     = port_global_enable && transmit_enable;
  assign frame_len   = fmt.word_nine ? LEN_NINE : LEN_EIGHT;
  assign accept_data = wr_data && transmit_empty_flag && !hold_full;
  assign break_start = tx_live && send_break_bit && (state == TX_IDLE);
  assign load        = tx_live && hold_full && !send_break_bit &&
                       ((state == TX_IDLE) || frame_done);
  assign frame_done  = tick && (state == TX_STOP) && (!fmt.stop_two || bit_cnt[0]);

  // Holding register; its full flag is cleared on disable so residual data is dropped.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      holding   <= '0;
      hold_full <= 1'b0;
    end else if (CE) begin
      if (!port_global_enable) begin
        hold_full <= 1'b0;
      end else if (accept_data) begin
        holding   <= req.writedata[7:0];
        hold_full <= 1'b1;
      end else if (load) begin
        hold_full <= 1'b0;
      end
    end
  end

  // Transmit sequencer.
  always_comb begin
    next_state = state;
    case (state)
      TX_IDLE: begin
        if (break_start) begin
          next_state = TX_START;
        end else if (load) begin
          next_state = TX_START;
        end
      end
      TX_START: begin
        if (tick) begin
          next_state = send_break_bit ? TX_BREAK : TX_DATA;
        end
      end
      TX_DATA: begin
        if (tick && (bit_cnt == frame_len - 4'h1)) begin
          next_state = TX_STOP;
        end
      end
      TX_BREAK: begin
        if (tick && (bit_cnt == BREAK_BITS - 4'h1) && !send_break_bit) begin
          next_state = TX_STOP;
        end
      end
      TX_STOP: begin
        if (load) begin
          next_state = TX_START;
        end else if (frame_done) begin
          next_state = TX_IDLE;
        end
      end
      default: begin
        next_state = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= TX_IDLE;
    end else if (CE) begin
      state <= tx_live ? next_state : TX_IDLE;
    end
  end

  // Bit counter restarts at every state change.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_cnt <= '0;
    end else if (CE) begin
      if (!tx_live || (next_state != state)) begin
        bit_cnt <= '0;
      end else if (tick && (state == TX_BREAK) && (bit_cnt == BREAK_BITS - 4'h1)) begin
        bit_cnt <= '0;
      end else if (tick) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // Shift register goes out least significant bit first.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      transmit_shift_register <= '1;
    end else if (CE) begin
      if (!tx_live) begin
        transmit_shift_register <= '1;
      end else if (load) begin
        transmit_shift_register <= build_frame(holding, control1[C1_NINTH], fmt);
      end else if (tick && (state == TX_DATA)) begin
        transmit_shift_register <= {1'b1, transmit_shift_register[8:1]};
      end
    end
  end

  ufet_baud_gen #(
    .DIV_W   (DIV_W)
  ) u_baud (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .ce      (CE),
    .run     (tx_live && (state != TX_IDLE)),
    .restart (state == TX_IDLE),
    .speed   (control2[C2_SPEED]),
    .divisor (baud_divisor),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Serial output pin.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SERIAL_OUT_PIN <= 1'b1;
    end else if (CE) begin
      case (tx_live ? next_state : TX_IDLE)
        TX_START: SERIAL_OUT_PIN <= 1'b0;
        TX_BREAK: SERIAL_OUT_PIN <= 1'b0;
        TX_DATA: begin
          SERIAL_OUT_PIN <= (state == TX_DATA) ?
                            ((tick) ? transmit_shift_register[1] : transmit_shift_register[0]) :
                            transmit_shift_register[0];
        end
        default: SERIAL_OUT_PIN <= 1'b1;
      endcase
    end
  end

  assign SERIAL_OUT_OE    = tx_live;
  assign SERIAL_IN_ACTIVE = port_global_enable && control2[C2_RX_EN];

  ufet_pin_sync u_in_sync (
    .clk    (CLK),
    .arst_n (ARST_N),
    .ce     (CE),
    .pin    (SERIAL_IN_PIN),
    .level  (line_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags and the status-read then data-write clear sequence.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      armed <= 1'b0;
    end else if (CE) begin
      if (rd_status) begin
        armed <= 1'b1;
      end else if (wr_data) begin
        armed <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      transmit_empty_flag <= 1'b1;
    end else if (CE) begin
      if (!port_global_enable || load) begin
        transmit_empty_flag <= 1'b1;
      end else if (accept_data && armed) begin
        transmit_empty_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      transmit_idle_flag <= 1'b1;
    end else if (CE) begin
      if (!port_global_enable || frame_done) begin
        transmit_idle_flag <= 1'b1;
      end else if (accept_data && armed) begin
        transmit_idle_flag <= 1'b0;
      end
    end
  end

  // No receiver is built; its flags hold their disabled values.
  assign receive_idle_flag = 1'b1;
  assign rx_errs_clear     = 1'b0;

  assign IRQ = transmit_empty_flag && transmit_empty_irq_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, registered at the answering edge.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      AVS_READDATA <= '0;
    end else if (take && req.read) begin
      AVS_READDATA <= '0;
      case (req.address)
        OFS_STATUS: begin
          AVS_READDATA[ST_LINE]     <= line_level;
          AVS_READDATA[ST_PAR_ERR]  <= rx_errs_clear;
          AVS_READDATA[ST_NOISE]    <= rx_errs_clear;
          AVS_READDATA[ST_FRAME]    <= rx_errs_clear;
          AVS_READDATA[ST_OVERRUN]  <= rx_errs_clear;
          AVS_READDATA[ST_RX_IDLE]  <= receive_idle_flag;
          AVS_READDATA[ST_RX_AVAIL] <= rx_errs_clear;
          AVS_READDATA[ST_TX_IDLE]  <= transmit_idle_flag;
          AVS_READDATA[ST_TX_EMPTY] <= transmit_empty_flag;
        end
        OFS_CONTROL1: AVS_READDATA[7:0] <= control1;
        OFS_CONTROL2: AVS_READDATA[7:0] <= control2;
        OFS_BAUD:     AVS_READDATA[DIV_W-1:0] <= baud_divisor;
        default:      AVS_READDATA <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  AST_IDLE_HIGH: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state == TX_IDLE) && $past(state == TX_IDLE) |-> SERIAL_OUT_PIN)
    else $error("Output not high while idle.");
  AST_DISABLE: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && !port_global_enable |=> transmit_empty_flag && transmit_idle_flag && !transmit_enable)
    else $error("Disable did not reset flags.");
  AST_START_LOW: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(state == TX_START) |-> !SERIAL_OUT_PIN)
    else $error("Start bit not low.");
  AST_WRITE_BLOCK: assert property (@(posedge CLK) disable iff (!ARST_N)
    wr_data && !transmit_empty_flag |=> $stable(holding))
    else $error("Write accepted while not empty.");
  AST_RELOAD: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(state == TX_START) |-> $past(state == TX_IDLE) || $past(state == TX_STOP))
    else $error("Frame started mid-frame.");
  AST_TX_OFF: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && !transmit_enable |-> !SERIAL_OUT_OE ##1 (state == TX_IDLE))
    else $error("Transmitter not reset.");
  AST_EMPTY_CLR: assert property (@(posedge CLK) disable iff (!ARST_N)
    $fell(transmit_empty_flag) |-> $past(armed) && $past(wr_data))
    else $error("Empty flag cleared without sequence.");
  AST_IDLE_SET: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && frame_done |=> transmit_idle_flag)
    else $error("Idle flag not set at frame end.");
  AST_STOP_HIGH: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state == TX_STOP) && $past(state == TX_STOP) |-> SERIAL_OUT_PIN)
    else $error("Stop bit not high.");

endmodule

// ===== bench/ufet_rx_model.sv
// Remote serial device: decodes frames seen on the port's output pin.
`timescale 1ns/1ps
module ufet_rx_model (
  // Line side.
  input  wire logic       clk,
  input  wire logic       line,
  input  wire logic [7:0] bit_cyc,
  input  wire logic [3:0] nbits,
  // Remote output and decoded frame.
  output logic            rx_line,
  output logic [8:0]      word,
  output logic            stop_ok,
  output logic [7:0]      frames
);
  int i;
  initial begin
    rx_line = 1'b1;
    word = '0;
    stop_ok = 1'b0;
    frames = '0;
    forever begin
      @(negedge line);
      repeat (bit_cyc / 2) @(posedge clk);
      word = '0;
      for (i = 0; i < nbits; i++) begin
        repeat (bit_cyc) @(posedge clk);
        word[i] = line;
      end
      repeat (bit_cyc) @(posedge clk);
      stop_ok = line;
      frames = frames + 8'h01;
    end
  end
endmodule

// ===== bench/ufet_uart_tb.sv
// Testbench: register accesses over Avalon-MM and frame checks at the remote model.
`timescale 1ns/1ps
module ufet_uart_tb
  import ufet_pkg::*;
;
  logic        CLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic [4:0]  adr = '0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdata;
  logic        wreq;
  logic        out_pin;
  logic        oe;
  logic        in_pin;
  logic        irq;
  logic        rxa;
  logic [3:0]  nbits = 4'h8;
  logic [8:0]  word;
  logic        stop_ok;
  logic [7:0]  frames;
  logic [7:0]  f0;
  logic [31:0] rdv;
  logic [7:0]  cfg [6] = '{8'h80, 8'hC1, 8'hB0, 8'hA0, 8'h88, 8'h84};
  logic [7:0]  dat [6] = '{8'hA5, 8'h55, 8'h07, 8'h07, 8'h3C, 8'h81};
  logic [8:0]  exw [6] = '{9'h0A5, 9'h155, 9'h007, 9'h087, 9'h03C, 9'h081};
  int          i;
  int          num_errors = 0;
  int          check_count = 0;
  always #2 CLK = ~CLK;
  ufet_uart #(.DIV_W(8)) i_dut (.CLK(CLK), .ARST_N(ARST_N), .CE(1'b1), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .SERIAL_OUT_PIN(out_pin), .SERIAL_OUT_OE(oe), .SERIAL_IN_PIN(in_pin), .SERIAL_IN_ACTIVE(rxa), .IRQ(irq));
  // A released output pin is seen at its pull-up level by the remote device.
  ufet_rx_model i_rem (.clk(CLK), .line(oe ? out_pin : 1'b1), .bit_cyc(8'h20), .nbits(nbits), .rx_line(in_pin),
    .word(word), .stop_ok(stop_ok), .frames(frames));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t ns: got %h, want %h", $time, seen, exp);
    end
  endtask
  // One Avalon access; the request is held until waitrequest is seen low.
  task automatic bus(input logic r, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    rd <= r;
    wr <= !r;
    @(posedge CLK);
    while (wreq !== 1'b0) begin
      n++;
      if (n > 50) begin
        num_errors++;
        final_report();
      end
      @(posedge CLK);
    end
    rdv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wf(input logic [8:0] exp);
    int n;
    for (n = 0; n < 1000 && frames == f0; n++) @(posedge CLK);
    if (frames == f0) begin
      num_errors++;
      final_report();
    end
    f0 = frames;
    chk({23'h0, word}, {23'h0, exp});
    chk({31'h0, stop_ok}, 32'h1);
  endtask
  task automatic send(input logic [7:0] d, input logic [8:0] exp);
    f0 = frames;
    bus(1'b1, OFS_STATUS, '0);
    bus(1'b0, OFS_DATA, {24'h0, d});
    wf(exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    bus(1'b1, OFS_STATUS, '0);
    chk(rdv, 32'h10B);
    bus(1'b1, OFS_CONTROL1, '0);
    chk(rdv, 32'h0);
    bus(1'b0, OFS_BAUD, 32'h1);
    bus(1'b0, OFS_CONTROL1, 32'h80);
    bus(1'b0, OFS_CONTROL2, 32'hE1);
    chk({28'h0, oe, out_pin, irq, rxa}, 32'hF);
    for (i = 0; i < 6; i++) begin
      bus(1'b0, OFS_CONTROL1, {24'h0, cfg[i]});
      nbits <= cfg[i][C1_WORD_LEN] ? 4'h9 : 4'h8;
      send(dat[i], exw[i]);
    end
    nbits <= 4'h8;
    bus(1'b0, OFS_CONTROL1, 32'h80);
    repeat (64) @(posedge CLK);
    f0 = frames;
    bus(1'b1, OFS_STATUS, '0);
    bus(1'b0, OFS_DATA, 32'h11);
    bus(1'b1, OFS_STATUS, '0);
    chk(rdv, 32'h109);
    bus(1'b0, OFS_DATA, 32'h22);
    bus(1'b1, OFS_STATUS, '0);
    chk(rdv, 32'h108);
    bus(1'b0, OFS_DATA, 32'h33);
    wf(9'h011);
    wf(9'h022);
    repeat (800) @(posedge CLK);
    chk({24'h0, frames}, {24'h0, f0});
    bus(1'b1, OFS_STATUS, '0);
    chk(rdv, 32'h10B);
    bus(1'b1, OFS_STATUS, '0);
    bus(1'b0, OFS_DATA, 32'h5A);
    repeat (100) @(posedge CLK);
    bus(1'b0, OFS_CONTROL1, 32'h0);
    chk({29'h0, oe, out_pin, rxa}, 32'h2);
    bus(1'b1, OFS_STATUS, '0);
    chk(rdv, 32'h10B);
    bus(1'b1, OFS_CONTROL2, '0);
    chk(rdv, 32'h21);
    bus(1'b1, OFS_BAUD, '0);
    chk(rdv, 32'h1);
    repeat (500) @(posedge CLK);
    bus(1'b0, OFS_CONTROL1, 32'h80);
    bus(1'b0, OFS_CONTROL2, 32'hA1);
    send(8'h96, 9'h096);
    bus(1'b1, OFS_STATUS, '0);
    bus(1'b0, OFS_DATA, 32'h0F);
    repeat (100) @(posedge CLK);
    bus(1'b0, OFS_CONTROL2, 32'h21);
    chk({31'h0, oe}, 32'h0);
    repeat (500) @(posedge CLK);
    f0 = frames;
    bus(1'b1, OFS_STATUS, '0);
    bus(1'b0, OFS_DATA, 32'hC3);
    bus(1'b0, OFS_CONTROL2, 32'hA1);
    wf(9'h0C3);
    f0 = frames;
    bus(1'b0, OFS_CONTROL1, 32'h82);
    repeat (700) @(posedge CLK);
    chk({24'h0, frames - f0}, 32'h1);
    chk({22'h0, word, stop_ok}, 32'h0);
    chk({31'h0, out_pin}, 32'h0);
    bus(1'b0, OFS_CONTROL1, 32'h80);
    repeat (300) @(posedge CLK);
    chk({31'h0, out_pin}, 32'h1);
    bus(1'b1, OFS_STATUS, '0);
    chk(rdv, 32'h10B);
    final_report();
  end
endmodule
